// ---- rtl/ridc_top.sv ----
// ridc_top: remote inputs, front button and brightness switching
`timescale 1ns/1ps
module ridc_top
  import ridc_pkg::*;
#(
  parameter logic [31:0] T_IND   = IND_CYC,
  parameter logic [31:0] T_MSG   = MSG_CYC,
  parameter logic [31:0] T_RET   = RET_CYC,
  parameter logic [31:0] T_CLR   = CLR_CYC,
  parameter logic [31:0] T_FLASH = FLASH_CYC,
  parameter logic [31:0] T_DEB   = DEB_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // terminals: [0] rear 1, [1] rear 2, [2] front button
  input  wire logic [2:0]  in_pin,
  input  wire logic [15:0] meas_value,
  // termination drives for rear inputs
  output logic      [1:0]  pull_up_en,
  output logic      [1:0]  pull_dn_en,
  // to display, alarm and access logic
  output ridc_disp_t       disp,
  output logic      [4:0]  bright_lvl,
  output logic             alarm_ack,
  output logic             access_en
);

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [4:0]  norm_lvl;          // normal brightness
  logic [4:0]  dim_lvl;           // dimmed brightness
  logic [11:0] mode_reg;          // three mode fields
  ridc_incfg_t incfg [2];         // rear input settings
  logic [15:0] peak_mem;          // highest since clear
  logic [15:0] valley_mem;        // lowest since clear

  wire wr_bright = wr && (addr == ADDR_BRIGHT);
  wire wr_mode   = wr && (addr == ADDR_MODE);
  wire wr_incfg  = wr && (addr == ADDR_INCFG);

  // register writes; reset gives the documented defaults
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      norm_lvl <= NORM_RST;
      dim_lvl  <= DIM_RST;
      mode_reg <= '0;
      incfg[0] <= INCFG_RST;
      incfg[1] <= INCFG_RST;
    end else begin
      if (wr_bright) begin
        norm_lvl <= wdata[4:0];
        dim_lvl  <= wdata[DIM_LSB +: 5];
      end
      if (wr_mode) mode_reg <= wdata[11:0];
      if (wr_incfg) begin
        incfg[0] <= ridc_incfg_t'(wdata[2:0]);
        incfg[1] <= ridc_incfg_t'(wdata[CFG_STRIDE +: 3]);
      end
    end
  end

  // ****************************************************************
  // per input conditioning and function decode
  // ****************************************************************
  logic [2:0] act;      // debounced active level
  logic [2:0] press;    // one pulse per closure
  logic [2:0] longp;    // one pulse when held for the clear time
  logic [2:0] is_ph, is_dh, is_pm, is_vm, is_tg, is_ack, is_acc, is_dim;

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_in
      logic        s1, s2;        // synchroniser pair
      logic        stab;          // debounced level
      logic        stab_d;        // for edge detect
      logic [31:0] deb_cnt;       // stability count
      logic [31:0] hold_cnt;      // time held active
      ridc_fn_t    raw_fn;
      ridc_fn_t    fn;
      wire         pol = (i < 2) ? incfg[i % 2].act_high : 1'b1;
      wire         lvl = ~(s2 ^ pol);

      assign raw_fn = ridc_fn_t'(mode_reg[i*MODE_W +: MODE_W]);
      // illegal choices per terminal fall back to no function
      always_comb begin
        fn = raw_fn;
        if (raw_fn > FN_DIM) fn = FN_NONE;
        if (i == 1 && raw_fn == FN_DIM) fn = FN_NONE;
        if (i == 2 && (raw_fn == FN_PHOLD || raw_fn == FN_DHOLD ||
            raw_fn >= FN_ACCESS)) fn = FN_NONE;
      end

      // a new level must stay put for the bounce time to count
      always_ff @(posedge mclk) begin
        if (!resetn) begin
          s1       <= 1'b0;
          s2       <= 1'b0;
          stab     <= 1'b0;
          stab_d   <= 1'b0;
          deb_cnt  <= '0;
          hold_cnt <= '0;
        end else begin
          s1     <= in_pin[i];
          s2     <= s1;
          stab_d <= stab;
          if (lvl == stab) deb_cnt <= '0;
          else if (deb_cnt >= T_DEB - 32'h1) begin
            stab    <= lvl;
            deb_cnt <= '0;
          end else deb_cnt <= deb_cnt + 32'h1;
          // saturating so the long pulse fires once
          if (!stab) hold_cnt <= '0;
          else if (hold_cnt < T_CLR) hold_cnt <= hold_cnt + 32'h1;
        end
      end

      // a no-function input leaves every decode low
      assign act[i]    = stab;
      assign press[i]  = stab && !stab_d;
      assign longp[i]  = stab && (hold_cnt == T_CLR - 32'h1);
      assign is_ph[i]  = fn == FN_PHOLD;
      assign is_dh[i]  = fn == FN_DHOLD;
      assign is_pm[i]  = fn == FN_PMEM;
      assign is_vm[i]  = fn == valley_memory_mode;
      assign is_tg[i]  = fn == FN_TOGGLE;
      assign is_ack[i] = fn == alarm_ack_mode;
      assign is_acc[i] = fn == setup_access_mode;
      assign is_dim[i] = fn == FN_DIM;
    end
  endgenerate

  // ****************************************************************
  // combined requests
  // ****************************************************************
  wire        ph_on     = |(act & is_ph);
  wire        dh_on     = |(act & is_dh);
  wire [2:0]  mem_fn    = is_pm | is_vm | is_tg;
  wire        mem_press = |(press & mem_fn);
  wire        mem_held  = |(act & mem_fn);
  wire        clr_peak  = |(longp & (is_pm | is_tg));
  wire        clr_vall  = |(longp & (is_vm | is_tg));
  wire        tg_press  = |(press & is_tg);
  wire        pm_press  = |(press & is_pm);
  wire        dim_on    = |(act & is_dim);

  // ****************************************************************
  // memories: cleared at power-up and by a long hold
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      peak_mem   <= PEAK_RST;
      valley_mem <= VALLEY_RST;
    end else begin
      if (clr_peak) peak_mem <= meas_value;
      else if ($signed(meas_value) > $signed(peak_mem))
        peak_mem <= meas_value;
      if (clr_vall) valley_mem <= meas_value;
      else if ($signed(meas_value) < $signed(valley_mem))
        valley_mem <= meas_value;
    end
  end

  // ****************************************************************
  // display view state
  // ****************************************************************
  typedef enum logic [1:0] {
    V_LIVE = 2'b00, V_PHOLD = 2'b01, V_DHOLD = 2'b10, V_MEM = 2'b11
  } ridc_view_t;

  ridc_view_t  view, next_view;
  logic        mem_valley;       // memory view shows valley
  logic        tg_next_valley;   // next toggle shows valley
  logic [15:0] hold_val;         // held or peak-held value
  logic [31:0] ret_cnt;          // memory view time left
  logic [31:0] flash_cnt;        // type tag time left
  logic [31:0] ind_cnt;          // hold tag phase

  // holds win over memory recall while their input is active
  always_comb begin
    next_view = view;
    case (view)
      V_LIVE, V_MEM: begin
        if (ph_on) next_view = V_PHOLD;
        else if (dh_on) next_view = V_DHOLD;
        else if (mem_press) next_view = V_MEM;
        else if (view == V_MEM && !mem_held && ret_cnt <= 32'h1)
          next_view = V_LIVE;
      end
      V_PHOLD: if (!ph_on) next_view = dh_on ? V_DHOLD : V_LIVE;
      V_DHOLD: if (!dh_on) next_view = ph_on ? V_PHOLD : V_LIVE;
      default: next_view = V_LIVE;
    endcase
  end

  wire entering = next_view != view;

  // view registers and timers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      view           <= V_LIVE;
      mem_valley     <= 1'b0;
      tg_next_valley <= 1'b0;
      hold_val       <= '0;
      ret_cnt        <= '0;
      flash_cnt      <= '0;
      ind_cnt        <= '0;
    end else begin
      view <= next_view;
      // hold value: captured on entry, then max or frozen
      if (entering) hold_val <= meas_value;
      else if (view == V_PHOLD &&
               $signed(meas_value) > $signed(hold_val))
        hold_val <= meas_value;
      // recall selection and timers
      if (mem_press && view != V_PHOLD && view != V_DHOLD) begin
        ret_cnt <= T_RET;
        if (tg_press) begin
          mem_valley     <= tg_next_valley;
          tg_next_valley <= !tg_next_valley;
          flash_cnt      <= T_FLASH;
        end else begin
          mem_valley <= !pm_press;
          flash_cnt  <= '0;
        end
      end else begin
        if (mem_held) ret_cnt <= T_RET;
        else if (ret_cnt != '0) ret_cnt <= ret_cnt - 32'h1;
        if (flash_cnt != '0) flash_cnt <= flash_cnt - 32'h1;
      end
      // indicator phase restarts on every hold entry
      if (entering || ind_cnt >= T_IND - 32'h1) ind_cnt <= '0;
      else ind_cnt <= ind_cnt + 32'h1;
    end
  end

  // ****************************************************************
  // output selection
  // ****************************************************************
  wire        tag_now = ind_cnt >= T_IND - T_MSG;
  ridc_disp_t next_disp;

  always_comb begin
    next_disp = '{sel: SEL_LIVE, value: meas_value};
    case (view)
      V_PHOLD: next_disp = '{sel: tag_now ? SEL_PH_TAG : SEL_HOLD,
                             value: hold_val};
      V_DHOLD: next_disp = '{sel: tag_now ? SEL_DH_TAG : SEL_HOLD,
                             value: hold_val};
      V_MEM: begin
        if (flash_cnt != '0)
          next_disp.sel = mem_valley ? SEL_VALLEY_TAG : SEL_PEAK_TAG;
        else next_disp.sel = mem_valley ? SEL_VALLEY : SEL_PEAK;
        next_disp.value = mem_valley ? valley_mem : peak_mem;
      end
      default: next_disp = '{sel: SEL_LIVE, value: meas_value};
    endcase
  end

  // read mux; unmapped addresses read zero
  logic [31:0] next_rdata;
  always_comb begin
    case (addr)
      ADDR_BRIGHT: next_rdata = {19'h0, dim_lvl, 3'h0, norm_lvl};
      ADDR_MODE:   next_rdata = {20'h0, mode_reg};
      ADDR_INCFG:  next_rdata = {25'h0, incfg[1], 1'b0, incfg[0]};
      ADDR_STATUS: next_rdata = {25'h0, disp.sel, 1'b0, act};
      ADDR_PEAK:   next_rdata = {16'h0, peak_mem};
      ADDR_VALLEY: next_rdata = {16'h0, valley_mem};
      default:     next_rdata = 32'h0;
    endcase
  end

  // every output from a flip-flop
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata      <= 32'h0;
      disp       <= '{sel: SEL_LIVE, value: 16'h0};
      bright_lvl <= NORM_RST;
      alarm_ack  <= 1'b0;
      access_en  <= 1'b0;
      pull_up_en <= 2'b11;
      pull_dn_en <= 2'b00;
    end else begin
      rdata      <= rd ? next_rdata : 32'h0;
      disp       <= next_disp;
      bright_lvl <= dim_on ? dim_lvl : norm_lvl;
      alarm_ack  <= |(press & is_ack);
      access_en  <= |(act & is_acc);
      pull_up_en <= {incfg[1].term == TERM_UP,
                     incfg[0].term == TERM_UP};
      pull_dn_en <= {incfg[1].term == TERM_DOWN,
                     incfg[0].term == TERM_DOWN};
    end
  end

endmodule

// ---- shared/ridc_pkg.sv ----
// ridc_pkg: constants, mode codes and carrier types for the remote input block
package ridc_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam longint CLK_HZ     = 50_000_000;       // mclk rate
  localparam longint CYC_PER_MS = CLK_HZ / 1000;    // cycles per ms
  localparam longint IND_MS     = 8000;             // hold tag period
  localparam longint MSG_MS     = 1000;             // tag visible time
  localparam longint RET_MS     = 20000;            // memory view timeout
  localparam longint CLR_MS     = 2000;             // hold time to clear
  localparam longint FLASH_MS   = 1000;             // type tag before view
  localparam longint DEB_MS     = 10;               // contact bounce time
  localparam logic [31:0] IND_CYC   = 32'(IND_MS * CYC_PER_MS);
  localparam logic [31:0] MSG_CYC   = 32'(MSG_MS * CYC_PER_MS);
  localparam logic [31:0] RET_CYC   = 32'(RET_MS * CYC_PER_MS);
  localparam logic [31:0] CLR_CYC   = 32'(CLR_MS * CYC_PER_MS);
  localparam logic [31:0] FLASH_CYC = 32'(FLASH_MS * CYC_PER_MS);
  localparam logic [31:0] DEB_CYC   = 32'(DEB_MS * CYC_PER_MS);

  // ****************************************************************
  // register map (byte addresses) and reset values
  // ****************************************************************
  localparam logic [7:0]  ADDR_BRIGHT = 8'h00; // normal / dimmed level
  localparam logic [7:0]  ADDR_MODE   = 8'h04; // function per input
  localparam logic [7:0]  ADDR_INCFG  = 8'h08; // termination, level
  localparam logic [7:0]  ADDR_STATUS = 8'h0C; // live state
  localparam logic [7:0]  ADDR_PEAK   = 8'h10; // stored peak
  localparam logic [7:0]  ADDR_VALLEY = 8'h14; // stored valley
  localparam logic [4:0]  NORM_RST    = 5'h10; // normal level 16
  localparam logic [4:0]  DIM_RST     = 5'h02; // dimmed level 2
  localparam int          DIM_LSB     = 8;     // dim field position
  localparam int          MODE_W      = 4;     // bits per mode field
  localparam int          CFG_STRIDE  = 4;     // bits per input cfg
  localparam int          ST_SEL_LSB  = 4;     // status view field
  localparam logic [15:0] PEAK_RST    = 16'h8000; // most negative
  localparam logic [15:0] VALLEY_RST  = 16'h7FFF; // most positive

  // ****************************************************************
  // input functions, terminations, displayed item
  // ****************************************************************
  typedef enum logic [3:0] {
    FN_NONE = 4'h0, FN_PHOLD = 4'h1, FN_DHOLD = 4'h2, FN_PMEM = 4'h3,
    FN_VMEM = 4'h4, FN_TOGGLE = 4'h5, FN_ACK = 4'h6, FN_ACCESS = 4'h7,
    FN_DIM = 4'h8
  } ridc_fn_t;
  localparam ridc_fn_t valley_memory_mode = FN_VMEM;
  localparam ridc_fn_t alarm_ack_mode     = FN_ACK;
  localparam ridc_fn_t setup_access_mode  = FN_ACCESS;

  typedef enum logic [1:0] {
    TERM_UP = 2'h0, TERM_DOWN = 2'h1, TERM_OPEN = 2'h2
  } ridc_term_t;

  typedef enum logic [2:0] {
    SEL_LIVE = 3'h0, SEL_PEAK = 3'h1, SEL_VALLEY = 3'h2, SEL_HOLD = 3'h3,
    SEL_PEAK_TAG = 3'h4, SEL_VALLEY_TAG = 3'h5,
    SEL_PH_TAG = 3'h6, SEL_DH_TAG = 3'h7
  } ridc_sel_t;

  // per rear input configuration
  typedef struct packed {
    logic       act_high; // 1: high level activates
    ridc_term_t term;     // resistor choice
  } ridc_incfg_t;
  localparam ridc_incfg_t INCFG_RST = '{act_high: 1'b1, term: TERM_UP};

  // display request to the digit driver
  typedef struct packed {
    ridc_sel_t   sel;
    logic [15:0] value;
  } ridc_disp_t;

endpackage

// ---- verification/ridc_asserts.sv ----
// ridc_asserts: port-level property checks for the remote input block
`timescale 1ns/1ps
module ridc_asserts
  import ridc_pkg::*;
#(
  parameter int T_IND = 200,
  parameter int T_RET = 100
) (
  // clock, reset and register port
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // terminals and measurement
  input wire logic [2:0]  in_pin,
  input wire logic [15:0] meas_value,
  // outputs under watch
  input wire logic [1:0]  pull_up_en,
  input wire logic [1:0]  pull_dn_en,
  input wire ridc_disp_t  disp,
  input wire logic [4:0]  bright_lvl,
  input wire logic        alarm_ack,
  input wire logic        access_en
);
  // ****************************************************************
  // shadow of the configuration as written over the bus
  // ****************************************************************
  logic [3:0]  m1, m2, mb;  // function per input
  logic [4:0]  nb, db;      // normal and dimmed level
  logic [2:0]  quiet;       // cycles since a config write, saturating
  logic [15:0] ret_cnt;     // peak view age after raw button release
  wire cfg_wr  = wr && (addr == ADDR_MODE || addr == ADDR_BRIGHT);
  wire settled = (quiet >= 3'h4);  // write plus registered output
  wire ph_only = (m1 == FN_PHOLD) && (m2 == FN_NONE);
  wire dh_only = (m1 == FN_DHOLD) && (m2 == FN_NONE);
  wire btn_mem = settled && (mb == FN_PMEM);

  // shadow mirrors reset values so checks hold right after release
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      {mb, m2, m1} <= 12'h000;
      nb <= NORM_RST;
      db <= DIM_RST;
      quiet <= 3'h7;
      ret_cnt <= 16'h0000;
    end else begin
      if (wr && addr == ADDR_MODE) begin
        {mb, m2, m1} <= wdata[11:0];
      end
      if (wr && addr == ADDR_BRIGHT) begin
        {db, nb} <= {wdata[12:8], wdata[4:0]};
      end
      quiet <= cfg_wr ? 3'h0 : ((quiet == 3'h7) ? quiet : quiet + 3'h1);
      ret_cnt <= (disp.sel == SEL_PEAK && !in_pin[2]) ?
                 ret_cnt + 16'h0001 : 16'h0000;
    end
  end

  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_reset_out;
    $rose(resetn) |-> pull_up_en == 2'h3 && pull_dn_en == 2'h0 &&
      bright_lvl == NORM_RST && disp == '0;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not at reset values");
  property p_dim_level;
    settled && m1 != FN_DIM |-> bright_lvl == nb;
  endproperty
  a_dim_level: assert property (p_dim_level)
    else $error("brightness not at normal level");
  property p_dim_range;
    settled |-> bright_lvl == nb || bright_lvl == db;
  endproperty
  a_dim_range: assert property (p_dim_range)
    else $error("brightness neither normal nor dimmed");
  property p_ack_pulse;
    alarm_ack |=> !alarm_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("acknowledge longer than one cycle");
  property p_ack_mode;
    settled && alarm_ack |-> m1 == FN_ACK || m2 == FN_ACK || mb == FN_ACK;
  endproperty
  a_ack_mode: assert property (p_ack_mode)
    else $error("acknowledge without an acknowledge input");
  property p_access_mode;
    settled && access_en |-> m1 == FN_ACCESS || m2 == FN_ACCESS;
  endproperty
  a_access_mode: assert property (p_access_mode)
    else $error("access enable without an access input");
  property p_term_excl;
    (pull_up_en & pull_dn_en) == 2'h0;
  endproperty
  a_term_excl: assert property (p_term_excl)
    else $error("pull-up and pull-down both on");
  property p_peak_rise;
    ph_only && disp.sel == SEL_HOLD && $past(disp.sel) == SEL_HOLD |->
      $signed(disp.value) >= $signed($past(disp.value));
  endproperty
  a_peak_rise: assert property (p_peak_rise)
    else $error("peak hold value fell");
  property p_hold_freeze;
    dh_only && disp.sel == SEL_HOLD && $past(disp.sel) == SEL_HOLD |->
      $stable(disp.value);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze)
    else $error("display hold value moved");
  property p_hold_tag;
    $rose(disp.sel == SEL_HOLD) |-> ##[1:T_IND]
      disp.sel inside {SEL_PH_TAG, SEL_DH_TAG, SEL_LIVE};
  endproperty
  a_hold_tag: assert property (p_hold_tag)
    else $error("hold tag missing within its period");
  property p_ret_max;
    btn_mem |-> ret_cnt <= T_RET + 16;
  endproperty
  a_ret_max: assert property (p_ret_max)
    else $error("memory view stayed too long");
  property p_ret_min;
    btn_mem && $fell(disp.sel == SEL_PEAK) |-> $past(ret_cnt) >= T_RET;
  endproperty
  a_ret_min: assert property (p_ret_min)
    else $error("memory view left too early");
endmodule

bind ridc_top ridc_asserts #(.T_IND(T_IND), .T_RET(T_RET)) u_asserts (
  .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .in_pin(in_pin), .meas_value(meas_value),
  .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .disp(disp),
  .bright_lvl(bright_lvl), .alarm_ack(alarm_ack), .access_en(access_en)
);

// ---- verification/ridc_contacts.sv ----
// ridc_contacts: switch contacts on the rear terminals and front button
`timescale 1ns/1ps
module ridc_contacts (
  // clock for the floating-line pattern
  input  wire logic       mclk,
  // contact closure per terminal
  input  wire logic [2:0] press,
  // resistor enables from the block
  input  wire logic [1:0] pull_up_en,
  input  wire logic [1:0] pull_dn_en,
  // terminal levels seen by the block
  output logic      [2:0] in_pin
);
  logic flt = 1'b0;  // open line: changes every cycle, never settles
  always @(posedge mclk) begin
    flt <= !flt;
  end
  // closed contact shorts to ground under pull-up, to supply otherwise
  assign in_pin[0] = press[0] ? !pull_up_en[0] :
                     (pull_up_en[0] | (~pull_dn_en[0] & flt));
  assign in_pin[1] = press[1] ? !pull_up_en[1] :
                     (pull_up_en[1] | (~pull_dn_en[1] & flt));
  assign in_pin[2] = press[2];  // front button reads high when pressed
endmodule

// ---- verification/tb_top.sv ----
// tb_top: directed bench for the remote input block
`timescale 1ns/1ps
module tb_top
  import ridc_pkg::*;
;
  localparam int TI = 32'h000000C8;  // shortened hold tag period
  localparam int TR = 32'h00000064;  // shortened memory view timeout
  logic        mclk, resetn, wr, rd, alarm_ack, access_en;
  logic [7:0]  addr, seen;
  logic [31:0] wdata, rdata;
  logic [2:0]  press, in_pin;
  logic [15:0] meas_value;
  logic [1:0]  pull_up_en, pull_dn_en;
  logic [4:0]  bright_lvl;
  ridc_disp_t  disp;
  int          fails, cmp_count, acks;

  ridc_top #(.T_IND(TI), .T_MSG(32'h00000014), .T_RET(TR),
    .T_CLR(32'h00000032), .T_FLASH(32'h0000000A), .T_DEB(32'h00000004)
  ) dut (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .in_pin(in_pin),
    .meas_value(meas_value), .pull_up_en(pull_up_en),
    .pull_dn_en(pull_dn_en), .disp(disp), .bright_lvl(bright_lvl),
    .alarm_ack(alarm_ack), .access_en(access_en));
  ridc_contacts u_contacts (.mclk(mclk), .press(press),
    .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .in_pin(in_pin));

  // ****************************************************************
  // clock, observers and bus tasks
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #10 mclk = !mclk;
  end
  // views met since last clear, acknowledge pulses counted
  always @(posedge mclk) begin
    seen[disp.sel] <= 1'b1;
    if (alarm_ack === 1'b1) begin
      acks <= acks + 1;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    // next edge: data launched by the strobe edge, read before it moves
    @(posedge mclk);
    chk(rdata, exp);
  endtask
  // contact change, then sync plus debounce plus output register
  task automatic setp(input int i, input logic v);
    press[i] <= v;
    repeat (12) @(posedge mclk);
  endtask
  task automatic conclude;
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog: the sequence needs about 1200 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    conclude();
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    {resetn, wr, rd, press, addr, wdata, seen} = '0;
    {fails, cmp_count, acks} = '0;
    meas_value = 16'h0064;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    rreg(ADDR_BRIGHT, 32'h00000210);
    rreg(ADDR_MODE, 32'h00000000);
    rreg(ADDR_INCFG, 32'h00000044);
    wreg(8'h20, 32'hFFFFFFFF);
    rreg(8'h20, 32'h00000000);
    setp(2, 1'b1);
    chk({29'h0, disp.sel}, {29'h0, SEL_LIVE});
    chk({31'h0, access_en}, 32'h00000000);
    setp(2, 1'b0);
    // dimming on rear 1, rear 2 may not dim
    wreg(ADDR_BRIGHT, 32'h0000000F);
    wreg(ADDR_INCFG, 32'h00000000);
    wreg(ADDR_MODE, 32'h00000088);
    setp(0, 1'b1);
    chk({27'h0, bright_lvl}, 32'h00000000);
    setp(0, 1'b0);
    chk({27'h0, bright_lvl}, 32'h0000000F);
    setp(1, 1'b1);
    chk({27'h0, bright_lvl}, 32'h0000000F);
    setp(1, 1'b0);
    // terminations, then a bouncing acknowledge closure
    wreg(ADDR_INCFG, 32'h00000025);
    repeat (3) @(posedge mclk);
    chk({28'h0, pull_up_en, pull_dn_en}, 32'h00000001);
    wreg(ADDR_INCFG, 32'h00000005);
    repeat (3) @(posedge mclk);
    chk({28'h0, pull_up_en, pull_dn_en}, 32'h00000009);
    wreg(ADDR_MODE, 32'h00000006);
    repeat (3) begin
      press[0] <= 1'b1;
      @(posedge mclk);
      press[0] <= 1'b0;
      @(posedge mclk);
    end
    setp(0, 1'b1);
    setp(0, 1'b0);
    chk(32'(acks), 32'h00000001);
    wreg(ADDR_MODE, 32'h00000070);
    setp(1, 1'b1);
    chk({31'h0, access_en}, 32'h00000001);
    rreg(ADDR_STATUS, 32'h00000002);
    setp(1, 1'b0);
    chk({31'h0, access_en}, 32'h00000000);
    // peak hold, then display hold
    wreg(ADDR_MODE, 32'h00000001);
    seen = '0;
    setp(0, 1'b1);
    meas_value <= 16'h00C8;
    repeat (5) @(posedge mclk);
    meas_value <= 16'h0032;
    repeat (5) @(posedge mclk);
    chk(32'(disp), 32'({SEL_HOLD, 16'h00C8}));
    repeat (TI) @(posedge mclk);
    chk({31'h0, seen[SEL_PH_TAG]}, 32'h00000001);
    setp(0, 1'b0);
    wreg(ADDR_MODE, 32'h00000002);
    meas_value <= 16'h012C;
    setp(0, 1'b1);
    meas_value <= 16'h0190;
    repeat (5) @(posedge mclk);
    chk(32'(disp), 32'({SEL_HOLD, 16'h012C}));
    repeat (TI) @(posedge mclk);
    chk({31'h0, seen[SEL_DH_TAG]}, 32'h00000001);
    setp(0, 1'b0);
    // peak memory on the front button: view, timeout, clear
    wreg(ADDR_MODE, 32'h00000300);
    meas_value <= 16'h01F4;
    setp(2, 1'b1);
    setp(2, 1'b0);
    chk(32'(disp), 32'({SEL_PEAK, 16'h01F4}));
    rreg(ADDR_PEAK, 32'h000001F4);
    repeat (78) @(posedge mclk);
    chk({29'h0, disp.sel}, {29'h0, SEL_PEAK});
    repeat (30) @(posedge mclk);
    chk({29'h0, disp.sel}, {29'h0, SEL_LIVE});
    meas_value <= 16'h007B;
    press[2] <= 1'b1;
    repeat (70) @(posedge mclk);
    setp(2, 1'b0);
    rreg(ADDR_PEAK, 32'h0000007B);
    repeat (TR + 20) @(posedge mclk);
    // valley memory, then toggling between the two views
    rreg(ADDR_VALLEY, 32'h00000032);
    wreg(ADDR_MODE, 32'h00000400);
    setp(2, 1'b1);
    setp(2, 1'b0);
    chk(32'(disp), 32'({SEL_VALLEY, 16'h0032}));
    repeat (TR + 20) @(posedge mclk);
    wreg(ADDR_MODE, 32'h00000500);
    seen = '0;
    setp(2, 1'b1);
    setp(2, 1'b0);
    chk({31'h0, seen[SEL_PEAK_TAG]}, 32'h00000001);
    chk(32'(disp), 32'({SEL_PEAK, 16'h007B}));
    seen = '0;
    setp(2, 1'b1);
    setp(2, 1'b0);
    chk({31'h0, seen[SEL_VALLEY_TAG]}, 32'h00000001);
    chk(32'(disp), 32'({SEL_VALLEY, 16'h0032}));
    conclude();
  end
endmodule
